// file: rtl/sci_host_regs.sv
// I2C slave with control and status registers for one card slot.
`timescale 1ns/10ps
// Functional notes
// - Slave address 7-bit 0x20 plus straps; byte 0x40..0x4E, bit 0 R/W.
// - Unconnected straps give address byte 48h.
// - Write: address with R/W low, ACK, data byte loads control, ACK.
// - Read: address with R/W high, ACK, status byte out, master NACK.
// - Control register is zero after reset.
// - Session bit set starts activation; cleared starts deactivation.
// - Session bit acts on transitions only, never on its level.
// - Warm restart bit requests warm reset; hardware clears it later.
// - Bit 2 selects 3 V when one, 5 V when zero.
// - Bit 3 halts the card clock at the chosen level.
// - Bit 4 chooses halted clock level, high when one.
// - Bits 5 and 6 pick oscillator divided by 8, 4, 2 or 1.
// - Bit 7 bridges the three card lines to host lines.
// - Status reads 0x04 right after reset.
// - Status bit 0 follows card presence.
// - Presence change flag: set on edges, clear on read, interrupts.
// - Status bit 2 shows the card I/O line level.
// - Supply fault flag: set on fault, clear on read, interrupts.
// - Protection fault during session: clear on read, interrupts.
// - No answer within 40000 card clocks sets mute flag.
// - Answer before 400 card clocks sets early flag.
// - Status bit 7 shows the session live.
// - Active-low interrupt while any interrupting flag is set.
module sci_host_regs #(
  parameter int MUTE_CYCLES = sci_pkg::MUTE_CARD_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_osc_clock,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic [2:0] i_addr_sel,
  input wire logic i_card_present,
  input wire logic i_supply_fault,
  input wire logic i_protection_fault,
  input wire logic i_session_live,
  input wire logic i_atr_wait,
  input wire logic [2:0] i_card_lines,
  output logic [2:0] o_card_lines,
  output logic [2:0] o_card_lines_oe,
  input wire logic [2:0] i_host_lines,
  output logic [2:0] o_host_lines,
  output logic [2:0] o_host_lines_oe,
  output logic o_activate_req,
  output logic o_deactivate_req,
  output logic o_warm_reset_req,
  output logic o_vcc_3v_sel,
  output logic o_card_clock,
  output logic o_host_irq_n
);
  logic [14:0] sync1_q, sync2_q;
  logic [4:0] prev_q;
  logic [2:0] addr_q;
  logic [1:0] strap_cnt_q;
  sci_pkg::sci_i2c_state_t st_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic rw_q, ack_on_q;
  logic [7:0] ctrl_q;
  logic ctrl_tgl_q, run_prev_q, warm_prev_q;
  logic presence_change_flag_q, supply_fault_flag_q, protection_fault_flag_q, mute_q, early_q;
  logic [2:0] ev_s1_q, ev_s2_q, ev_prev_q;
  logic [2:0] ev_tgl_q;
  logic osc_rst_req_q, osc_done_q;
  logic [1:0] done_sync_q;
  logic s_scl, s_sda, s_card_present_in, s_supply_fault_flag, s_protection_fault_flag, s_live;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic rd_load, ctrl_wr, run_rise, ev_ans, ev_mute, ev_early;
  logic [7:0] status_w;

  // Pins from outside the clock domain pass two flops first.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync1_q <= sci_pkg::SYNC_RESET;
      sync2_q <= sci_pkg::SYNC_RESET;
      prev_q <= 5'h03;
    end else begin
      sync1_q <= {i_host_lines, i_card_lines, i_session_live,
                  i_protection_fault, i_supply_fault, i_card_present,
                  i_addr_sel, i_sda, i_scl};
      sync2_q <= sync1_q;
      prev_q <= {sync2_q[7:5], sync2_q[1:0]};
    end
  end

  assign s_scl = sync2_q[0];
  assign s_sda = sync2_q[1];
  assign s_card_present_in = sync2_q[5];
  assign s_supply_fault_flag = sync2_q[6];
  assign s_protection_fault_flag = sync2_q[7];
  assign s_live = sync2_q[8];
  assign scl_rise = s_scl & ~prev_q[0];
  assign scl_fall = ~s_scl & prev_q[0];
  assign start_c = s_scl & prev_q[0] & prev_q[1] & ~s_sda;
  assign stop_c = s_scl & prev_q[0] & ~prev_q[1] & s_sda;

  // Straps are caught once the synchroniser holds real pin levels.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      addr_q <= sci_pkg::ADDR_STRAP_DEFAULT;
      strap_cnt_q <= 2'h0;
    end else if (strap_cnt_q != sci_pkg::STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      addr_q <= sync2_q[4:2];
    end
  end

  assign status_w = {s_live, early_q, mute_q, protection_fault_flag_q,
                     supply_fault_flag_q, sync2_q[9], presence_change_flag_q, s_card_present_in};
  assign rd_load = (st_q == sci_pkg::ST_AACK) & scl_fall & ack_on_q
                   & rw_q;
  assign ctrl_wr = (st_q == sci_pkg::ST_WDATA) & scl_rise
                   & (cnt_q == 3'h7);

  // A START in any state restarts the frame; STOP always idles.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q <= sci_pkg::ST_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      ack_on_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (start_c) begin
      st_q <= sci_pkg::ST_ADDR;
      cnt_q <= 3'h0;
      ack_on_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (stop_c) begin
      st_q <= sci_pkg::ST_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      unique case (st_q)
        sci_pkg::ST_IDLE, sci_pkg::ST_WAIT: begin
        end
        sci_pkg::ST_ADDR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], s_sda};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              // A foreign address is never acknowledged.
              if (sh_q[6:0] == {sci_pkg::ADDR_BYTE_BASE[7:4], addr_q}) begin
                st_q <= sci_pkg::ST_AACK;
                rw_q <= s_sda;
              end else begin
                st_q <= sci_pkg::ST_WAIT;
              end
            end
          end
        end
        sci_pkg::ST_AACK, sci_pkg::ST_WACK: begin
          if (scl_fall) begin
            if (!ack_on_q) begin
              ack_on_q <= 1'b1;
              o_sda_oe <= 1'b1;
            end else begin
              ack_on_q <= 1'b0;
              cnt_q <= 3'h0;
              if (st_q == sci_pkg::ST_AACK && rw_q) begin
                st_q <= sci_pkg::ST_RDATA;
                sh_q <= status_w;
                o_sda_oe <= ~status_w[7];
              end else if (st_q == sci_pkg::ST_AACK) begin
                st_q <= sci_pkg::ST_WDATA;
                o_sda_oe <= 1'b0;
              end else begin
                st_q <= sci_pkg::ST_WAIT;
                o_sda_oe <= 1'b0;
              end
            end
          end
        end
        sci_pkg::ST_WDATA: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], s_sda};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              st_q <= sci_pkg::ST_WACK;
            end
          end
        end
        sci_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == 3'h7) begin
              st_q <= sci_pkg::ST_RACK;
              o_sda_oe <= 1'b0;
            end else begin
              cnt_q <= cnt_q + 3'h1;
              sh_q <= {sh_q[6:0], 1'b0};
              o_sda_oe <= ~sh_q[6];
            end
          end
        end
        sci_pkg::ST_RACK: begin
          // Only one status byte is offered; the master's bit ends it.
          if (scl_rise) begin
            st_q <= sci_pkg::ST_WAIT;
          end
        end
      endcase
    end
  end

  assign o_sda = 1'b0;
  assign o_card_lines = 3'h0;
  assign o_host_lines = 3'h0;

  // Hardware clear of the warm bit loses to a write in the same cycle.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_q <= sci_pkg::CTRL_RESET;
      ctrl_tgl_q <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_q <= {sh_q[6:0], s_sda};
      ctrl_tgl_q <= ~ctrl_tgl_q;
    end else if (ev_ans | ev_mute) begin
      ctrl_q[sci_pkg::CTL_WARM] <= 1'b0;
    end
  end

  assign run_rise = ctrl_q[sci_pkg::CTL_RUN] & ~run_prev_q;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      run_prev_q <= 1'b0;
      warm_prev_q <= 1'b0;
      o_activate_req <= 1'b0;
      o_deactivate_req <= 1'b0;
      o_warm_reset_req <= 1'b0;
      o_vcc_3v_sel <= 1'b0;
    end else begin
      run_prev_q <= ctrl_q[sci_pkg::CTL_RUN];
      warm_prev_q <= ctrl_q[sci_pkg::CTL_WARM];
      o_activate_req <= run_rise;
      o_deactivate_req <= ~ctrl_q[sci_pkg::CTL_RUN] & run_prev_q;
      o_warm_reset_req <= ctrl_q[sci_pkg::CTL_WARM] & ~warm_prev_q;
      o_vcc_3v_sel <= ctrl_q[sci_pkg::CTL_VSEL];
    end
  end

  // The oscillator may be far slower than this clock, so its reset is held
  // until that domain reports it back, and its events are ignored till then.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      osc_rst_req_q <= 1'b1;
      done_sync_q <= 2'h0;
    end else begin
      done_sync_q <= {done_sync_q[0], osc_done_q};
      if (done_sync_q[1]) begin
        osc_rst_req_q <= 1'b0;
      end
    end
  end

  // Events from the card clock domain arrive as toggles.
  always_ff @(posedge i_clock) begin
    if (i_rst || osc_rst_req_q) begin
      ev_s1_q <= 3'h0;
      ev_s2_q <= 3'h0;
      ev_prev_q <= 3'h0;
    end else begin
      ev_s1_q <= ev_tgl_q;
      ev_s2_q <= ev_s1_q;
      ev_prev_q <= ev_s2_q;
    end
  end

  assign ev_ans = ev_s2_q[0] ^ ev_prev_q[0];
  assign ev_mute = ev_s2_q[1] ^ ev_prev_q[1];
  assign ev_early = ev_s2_q[2] ^ ev_prev_q[2];

  // In every flag the set term wins over the clear term.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      presence_change_flag_q <= 1'b0;
      supply_fault_flag_q <= 1'b0;
      protection_fault_flag_q <= 1'b0;
      mute_q <= 1'b0;
      early_q <= 1'b0;
      o_host_irq_n <= 1'b1;
    end else begin
      presence_change_flag_q <= (s_card_present_in ^ prev_q[2]) | (presence_change_flag_q & ~rd_load);
      supply_fault_flag_q <= (s_supply_fault_flag & ~prev_q[3]) | (supply_fault_flag_q & ~rd_load);
      protection_fault_flag_q <= (s_protection_fault_flag & ~prev_q[4] & s_live)
                | (protection_fault_flag_q & ~rd_load);
      mute_q <= ev_mute | (mute_q & ~rd_load & ~run_rise);
      early_q <= ev_early | (early_q & ~rd_load & ~run_rise);
      o_host_irq_n <= ~(presence_change_flag_q | supply_fault_flag_q | protection_fault_flag_q);
    end
  end

  // Open-drain bridge: a line follows whichever side pulled low first.
  // The guard hides our own release until the pull-up is seen.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_bridge
      logic [1:0] dir_q, guard_q;
      logic card_in, host_in, en;
      assign card_in = sync2_q[9 + g];
      assign host_in = sync2_q[12 + g];
      assign en = ctrl_q[sci_pkg::CTL_BRIDGE];
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          dir_q <= sci_pkg::BR_IDLE;
          guard_q <= 2'h0;
          o_card_lines_oe[g] <= 1'b0;
          o_host_lines_oe[g] <= 1'b0;
        end else if (dir_q == sci_pkg::BR_IDLE) begin
          if (guard_q != 2'h0) begin
            guard_q <= guard_q - 2'h1;
          end else if (en && !host_in) begin
            dir_q <= sci_pkg::BR_H2C;
            o_card_lines_oe[g] <= 1'b1;
          end else if (en && !card_in) begin
            dir_q <= sci_pkg::BR_C2H;
            o_host_lines_oe[g] <= 1'b1;
          end
        end else if (!en ||
                     (dir_q == sci_pkg::BR_H2C ? host_in : card_in)) begin
          dir_q <= sci_pkg::BR_IDLE;
          guard_q <= sci_pkg::BR_GUARD;
          o_card_lines_oe[g] <= 1'b0;
          o_host_lines_oe[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Card clock domain, on the oscillator.
  logic osc_rst_meta, osc_rst_q;
  logic [2:0] otgl_q;
  logic [3:0] ocfg_q;
  logic [1:0] oin1_q, oin2_q;
  logic oio_prev_q, card_clk_q, pass_q, answered_q;
  logic [1:0] div_cnt_q, half_w;
  logic [15:0] atr_cnt_q;
  logic card_cycle, io_fall;

  always_ff @(posedge i_osc_clock) begin
    osc_rst_meta <= osc_rst_req_q;
    osc_rst_q <= osc_rst_meta;
    osc_done_q <= osc_rst_q;
  end

  // The control byte is steady long before its toggle is seen here.
  always_ff @(posedge i_osc_clock) begin
    if (osc_rst_q) begin
      otgl_q <= 3'h0;
      ocfg_q <= 4'h0;
      oin1_q <= 2'h3;
      oin2_q <= 2'h3;
      oio_prev_q <= 1'b1;
    end else begin
      otgl_q <= {otgl_q[1:0], ctrl_tgl_q};
      if (otgl_q[2] != otgl_q[1]) begin
        ocfg_q <= ctrl_q[6:3];
      end
      oin1_q <= {i_atr_wait, i_card_lines[0]};
      oin2_q <= oin1_q;
      oio_prev_q <= oin2_q[0];
    end
  end

  always_comb begin
    unique case (ocfg_q[3:2])
      sci_pkg::DIV_BY8: half_w = sci_pkg::HALF_BY8;
      sci_pkg::DIV_BY4: half_w = sci_pkg::HALF_BY4;
      sci_pkg::DIV_BY2: half_w = sci_pkg::HALF_BY2;
      sci_pkg::DIV_NONE: half_w = sci_pkg::HALF_BY2;
    endcase
  end

  assign card_cycle = ~ocfg_q[0] & (pass_q |
                      ((div_cnt_q == half_w) & ~card_clk_q));
  assign io_fall = oio_prev_q & ~oin2_q[0];

  always_ff @(posedge i_osc_clock) begin
    if (osc_rst_q) begin
      div_cnt_q <= 2'h0;
      card_clk_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      pass_q <= ~ocfg_q[0] & (ocfg_q[3:2] == sci_pkg::DIV_NONE);
      if (ocfg_q[0]) begin
        div_cnt_q <= 2'h0;
        card_clk_q <= ocfg_q[1];
      end else if (div_cnt_q == half_w) begin
        div_cnt_q <= 2'h0;
        card_clk_q <= ~card_clk_q;
      end else begin
        div_cnt_q <= div_cnt_q + 2'h1;
      end
    end
  end

  // Undivided rate is the oscillator itself, so it cannot be a flop.
  assign o_card_clock = pass_q ? i_osc_clock : card_clk_q;

  always_ff @(posedge i_osc_clock) begin
    if (osc_rst_q) begin
      atr_cnt_q <= 16'h0000;
      answered_q <= 1'b0;
      ev_tgl_q <= 3'h0;
    end else if (!oin2_q[1]) begin
      atr_cnt_q <= 16'h0000;
      answered_q <= 1'b0;
    end else if (!answered_q) begin
      if (io_fall) begin
        answered_q <= 1'b1;
        ev_tgl_q[0] <= ~ev_tgl_q[0];
        if (atr_cnt_q < sci_pkg::EARLY_CARD_CYCLES) begin
          ev_tgl_q[2] <= ~ev_tgl_q[2];
        end
      end else if (card_cycle) begin
        atr_cnt_q <= atr_cnt_q + 16'h0001;
        if (atr_cnt_q == 16'(MUTE_CYCLES - 1)) begin
          answered_q <= 1'b1;
          ev_tgl_q[1] <= ~ev_tgl_q[1];
        end
      end
    end
  end

  property p_ctrl_reset;
    @(posedge i_clock) $fell(i_rst) |-> ctrl_q == 8'h00;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset)
    else $error("control not zero after reset");
  property p_status_reset;
    @(posedge i_clock) $fell(i_rst) |-> status_w == 8'h04;
  endproperty
  a_status_reset: assert property (p_status_reset)
    else $error("status not 0x04 after reset");
  property p_activate;
    @(posedge i_clock) disable iff (i_rst)
      $rose(ctrl_q[0]) |=> o_activate_req ##1 !o_activate_req;
  endproperty
  a_activate: assert property (p_activate)
    else $error("activation pulse wrong");
  property p_level;
    @(posedge i_clock) disable iff (i_rst)
      ctrl_q[0] [*2] |=> !o_activate_req && !o_deactivate_req;
  endproperty
  a_level: assert property (p_level)
    else $error("session acted on level");
  property p_warm_clear;
    @(posedge i_clock) disable iff (i_rst)
      (ev_ans || ev_mute) && !ctrl_wr |=> !ctrl_q[1];
  endproperty
  a_warm_clear: assert property (p_warm_clear)
    else $error("warm bit not cleared");
  property p_foreign;
    @(posedge i_clock) disable iff (i_rst)
      st_q == sci_pkg::ST_WAIT |-> !o_sda_oe;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("sda driven outside a transfer");
  property p_presence_change_flag;
    @(posedge i_clock) disable iff (i_rst)
      s_card_present_in != prev_q[2] |=> presence_change_flag_q ##1 !o_host_irq_n;
  endproperty
  a_presence_change_flag: assert property (p_presence_change_flag)
    else $error("presence change lost");
  property p_irq;
    @(posedge i_clock) disable iff (i_rst)
      !(presence_change_flag_q || supply_fault_flag_q || protection_fault_flag_q) |=> o_host_irq_n;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without flag");
  property p_rd_clear;
    @(posedge i_clock) disable iff (i_rst)
      rd_load && !ev_mute |=> !mute_q && sh_q[5] == $past(mute_q);
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("flag cleared before capture");
  property p_bridge_off;
    @(posedge i_clock) disable iff (i_rst)
      !ctrl_q[7] [*2] |-> o_card_lines_oe == 3'h0 && o_host_lines_oe == 3'h0;
  endproperty
  a_bridge_off: assert property (p_bridge_off)
    else $error("bridge drives while disabled");
  c_write: cover property (@(posedge i_clock) ctrl_wr);
  c_read: cover property (@(posedge i_clock) rd_load);
  c_act: cover property (@(posedge i_clock) o_activate_req);
  c_early: cover property (@(posedge i_clock) ev_early);
endmodule // sci_host_regs

// file: rtl/sci_pkg.sv
// Constants shared by the smart card host register block.
package sci_pkg;
  localparam logic [7:0] ADDR_BYTE_BASE = 8'h40;
  localparam logic [2:0] ADDR_STRAP_DEFAULT = 3'h4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h04;
  localparam logic [2:0] CTL_RUN = 3'h0;
  localparam logic [2:0] CTL_WARM = 3'h1;
  localparam logic [2:0] CTL_VSEL = 3'h2;
  localparam logic [2:0] CTL_HALT = 3'h3;
  localparam logic [2:0] CTL_HALT_LVL = 3'h4;
  localparam logic [2:0] CTL_DIV_LO = 3'h5;
  localparam logic [2:0] CTL_DIV_HI = 3'h6;
  localparam logic [2:0] CTL_BRIDGE = 3'h7;
  // Divider codes written as {clk_div_sel_hi, clk_div_sel_lo}.
  localparam logic [1:0] DIV_BY8 = 2'h0;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  localparam logic [1:0] DIV_BY2 = 2'h3;
  localparam logic [1:0] DIV_NONE = 2'h1;
  localparam logic [1:0] HALF_BY8 = 2'h3;
  localparam logic [1:0] HALF_BY4 = 2'h1;
  localparam logic [1:0] HALF_BY2 = 2'h0;
  localparam logic [15:0] EARLY_CARD_CYCLES = 16'h0190;
  localparam int MUTE_CARD_CYCLES = 40000;
  // Synchroniser order: host[2:0] card[2:0] live protection_fault_flag supply_fault_flag card_present_in
  // addr_sel[2:0] sda scl.
  localparam logic [14:0] SYNC_RESET = 15'h7E13;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [1:0] BR_IDLE = 2'h0;
  localparam logic [1:0] BR_H2C = 2'h1;
  localparam logic [1:0] BR_C2H = 2'h2;
  localparam logic [1:0] BR_GUARD = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WDATA = 3'h2,
    ST_WACK = 3'h6,
    ST_RDATA = 3'h7,
    ST_RACK = 3'h5,
    ST_WAIT = 3'h4
  } sci_i2c_state_t;
endpackage

// file: test/sci_i2c_master.sv
// Behavioural I2C bus master standing in for the host controller.
`timescale 1ns/10ps
module sci_i2c_master (
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  logic pull = 1'b0;
  // The bus has a pull-up, so a released line reads high, never stale.
  assign o_sda = !(pull | i_sda_oe);
  initial o_scl = 1'b1;
  // One bit slot: data set mid-low, sampled mid-high, 80 ns per slot.
  task automatic bit_io(input logic b, output logic r);
    pull = !b;
    #20 o_scl = 1'b1;
    #20 r = o_sda;
    #20 o_scl = 1'b0;
    #20;
  endtask
  task automatic xfer(input logic [7:0] adr, input logic [7:0] wd,
                      output logic ack, output logic [7:0] rd);
    logic r;
    rd = 8'h00;
    pull = 1'b1;
    #40 o_scl = 1'b0;
    #20;
    for (int i = 7; i >= 0; i--) bit_io(adr[i], r);
    bit_io(1'b1, r);
    ack = !r;
    if (ack) begin
      for (int i = 7; i >= 0; i--) bit_io(adr[0] | wd[i], rd[i]);
      bit_io(1'b1, r);
      if (!adr[0]) ack = !r;
    end
    pull = 1'b1;
    #20 o_scl = 1'b1;
    #40 pull = 1'b0;
    #80;
  endtask
endmodule // sci_i2c_master

// file: test/tb_sci_host_regs.sv
// Self-checking testbench for the smart card host register block.
`timescale 1ns/10ps
module tb_sci_host_regs;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_osc_clock = 1'b0;
  logic present = 1'b0, supply = 1'b0, protection_fault_flag = 1'b0, live = 1'b0;
  logic atr = 1'b0;
  logic [2:0] card_pull = 3'h0, host_pull = 3'h0;
  logic [2:0] card_oe, host_oe, card_lines, host_lines;
  logic scl, sda, sda_oe, act, deact, warm, vsel, card_clk, irq_n, ack;
  logic [7:0] rdata;
  logic [7:0] dev = 8'h48;
  logic [2:0] straps = 3'h4, card_val, host_val;
  logic sda_val;
  int num_errors = 0, n_checks = 0, n_act = 0, n_deact = 0;
  int n_warm = 0, n_cc = 0;
  // Card and host lines are pulled up; any party may pull them low.
  assign card_lines = ~(card_pull | card_oe);
  assign host_lines = ~(host_pull | host_oe);
  always #2 i_clock = !i_clock;
  initial begin
    #7;
    forever #40 i_osc_clock = !i_osc_clock;
  end
  always @(posedge i_clock) begin
    n_act += act;
    n_deact += deact;
    n_warm += warm;
  end
  always @(posedge card_clk) n_cc++;
  sci_host_regs #(.MUTE_CYCLES(800)) dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_osc_clock(i_osc_clock),
    .i_scl(scl), .i_sda(sda), .o_sda(sda_val), .o_sda_oe(sda_oe),
    .i_addr_sel(straps), .i_card_present(present), .i_supply_fault(supply),
    .i_protection_fault(protection_fault_flag), .i_session_live(live), .i_atr_wait(atr),
    .i_card_lines(card_lines), .o_card_lines(card_val),
    .o_card_lines_oe(card_oe),
    .i_host_lines(host_lines), .o_host_lines(host_val),
    .o_host_lines_oe(host_oe),
    .o_activate_req(act), .o_deactivate_req(deact),
    .o_warm_reset_req(warm), .o_vcc_3v_sel(vsel), .o_card_clock(card_clk),
    .o_host_irq_n(irq_n));
  sci_i2c_master m (.i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic clk(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic osc(input int n);
    repeat (n) @(posedge i_osc_clock);
    @(negedge i_clock);
  endtask
  task automatic wr(input logic [7:0] d);
    m.xfer(dev, d, ack, rdata);
    check({7'h00, ack}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] exp);
    m.xfer(dev | 8'h01, 8'h00, ack, rdata);
    check({7'h00, ack}, 8'h01);
    check(rdata, exp);
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 50 && irq_n !== 1'b0; i++) clk(1);
    if (i == 50) begin
      num_errors++;
      close_out();
    end
  endtask
  // Control values for each divider code and rising edges per 64 osc.
  logic [7:0] div_ctl [4] = '{8'h00, 8'h40, 8'h60, 8'h20};
  int div_edges [4] = '{8, 16, 32, 64};
  initial begin
    clk(8);
    i_rst = 1'b0;
    clk(6);
    rd(8'h04);
    check({7'h00, irq_n}, 8'h01);
    check({2'h0, sda_val, 1'b0, card_val, host_val}, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      m.xfer(8'h41 + 8'(2 * k), 8'h00, ack, rdata);
      check({7'h00, ack}, {7'h00, k == 4});
    end
    $display("test address done");
    wr(8'h05);
    check(n_act[7:0], 8'h01);
    check({7'h00, vsel}, 8'h01);
    wr(8'h05);
    check(n_act[7:0], 8'h01);
    wr(8'h07);
    check(n_warm[7:0], 8'h01);
    wr(8'h04);
    check(n_deact[7:0], 8'h01);
    wr(8'h00);
    check({7'h00, vsel}, 8'h00);
    $display("test control done");
    present = 1'b1;
    wait_irq();
    rd(8'h07);
    check({7'h00, irq_n}, 8'h01);
    rd(8'h05);
    supply = 1'b1;
    wait_irq();
    rd(8'h0D);
    live = 1'b1;
    protection_fault_flag = 1'b1;
    wait_irq();
    rd(8'h95);
    live = 1'b0;
    protection_fault_flag = 1'b0;
    rd(8'h05);
    card_pull[0] = 1'b1;
    rd(8'h01);
    card_pull[0] = 1'b0;
    $display("test status done");
    wr(8'h80);
    host_pull[0] = 1'b1;
    clk(10);
    check({5'h00, card_oe}, 8'h01);
    host_pull[0] = 1'b0;
    clk(12);
    check({2'h0, card_oe, host_oe}, 8'h00);
    card_pull[2] = 1'b1;
    clk(10);
    check({5'h00, host_oe}, 8'h04);
    card_pull[2] = 1'b0;
    wr(8'h00);
    host_pull[1] = 1'b1;
    clk(10);
    check({5'h00, card_oe}, 8'h00);
    host_pull[1] = 1'b0;
    $display("test bridge done");
    for (int k = 0; k < 4; k++) begin
      wr(div_ctl[k]);
      osc(10);
      n_cc = 0;
      osc(64);
      check({7'h00, n_cc >= div_edges[k] - 1 && n_cc <= div_edges[k] + 1},
            8'h01);
    end
    wr(8'h18);
    osc(10);
    n_cc = 0;
    osc(16);
    check({7'h00, card_clk}, 8'h01);
    check(n_cc[7:0], 8'h00);
    wr(8'h08);
    osc(10);
    check({7'h00, card_clk}, 8'h00);
    $display("test card clock done");
    wr(8'h23);
    atr = 1'b1;
    osc(1000);
    atr = 1'b0;
    rd(8'h25);
    wr(8'h23);
    check(n_warm[7:0], 8'h03);
    osc(4);
    atr = 1'b1;
    osc(20);
    card_pull[0] = 1'b1;
    osc(4);
    atr = 1'b0;
    card_pull[0] = 1'b0;
    rd(8'h45);
    rd(8'h05);
    wr(8'h23);
    check(n_warm[7:0], 8'h04);
    $display("test answer timing done");
    // A reset in mid-run must catch new straps and clear every flag.
    present = 1'b0;
    supply = 1'b0;
    straps = 3'h3;
    clk(2);
    i_rst = 1'b1;
    clk(8);
    i_rst = 1'b0;
    clk(6);
    dev = 8'h46;
    rd(8'h04);
    check({7'h00, irq_n}, 8'h01);
    m.xfer(8'h49, 8'h00, ack, rdata);
    check({7'h00, ack}, 8'h00);
    $display("test strap reset done");
    close_out();
  end
  // A hang is cut short and counted as a failure.
  initial begin
    #380000;
    num_errors++;
    close_out();
  end
endmodule // tb_sci_host_regs
